// ### osbsc_defs.svh
`ifndef OSBSC_DEFS_SVH
`define OSBSC_DEFS_SVH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define OSBSC_IDX_OSC_CTRL    6'h25
`define OSBSC_IDX_SUP_CTRL    6'h26
`define OSBSC_IDX_FLAGS       6'h2B
`define OSBSC_IDX_INT_STATUS  6'h30
`define OSBSC_IDX_INT_CLEAR   6'h31
`define OSBSC_IDX_INT_ENABLE  6'h32
`define OSBSC_IDX_INTERRUPT_OUT_A_CTRL   6'h33

// ****************************************************************
// Field positions.
// ****************************************************************
`define OSBSC_OSC_INVERT      7
`define OSBSC_OSC_OFFSET_CAL_MODE        6
`define OSBSC_OSC_HOUR12      5
`define OSBSC_OSC_LOW_JITTER_SELECT        4
`define OSBSC_OSC_DRIVE_HI    3
`define OSBSC_OSC_DRIVE_LO    2
`define OSBSC_OSC_CAP_HI      1
`define OSBSC_OSC_CAP_LO      0
`define OSBSC_SUP_DISABLE     4
`define OSBSC_SUP_REFRESH     3
`define OSBSC_SUP_MODE_HI     2
`define OSBSC_SUP_MODE_LO     1
`define OSBSC_SUP_THRESH      0
`define OSBSC_SUP_MASK        8'h1F
`define OSBSC_FLAG_BACKUP     0
`define OSBSC_EVT_TO_BAT      0
`define OSBSC_EVT_TO_MAIN     1
`define OSBSC_INTERRUPT_OUT_A_EN         0
`define OSBSC_INTERRUPT_OUT_A_LEVEL      1
`define OSBSC_INTERRUPT_OUT_A_BATIND     2
`define OSBSC_INTERRUPT_OUT_A_CLK        3

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define OSBSC_RST_OSC_CTRL    8'h00
`define OSBSC_RST_SUP_CTRL    8'h00
`define OSBSC_CLK_PERIOD_NS   25
`define OSBSC_INT_PULSE_NS    7812500

`endif

// ### osbsc_pkg.sv
package osbsc_pkg;

  typedef enum logic [1:0] {
    OSBSC_DRIVE_NORMAL = 2'h0,
    OSBSC_DRIVE_LOW    = 2'h1,
    OSBSC_DRIVE_HIGH   = 2'h2
  } osbsc_drive_t;

  typedef enum logic [1:0] {
    OSBSC_CAP_7P0  = 2'h0,
    OSBSC_CAP_6P0  = 2'h1,
    OSBSC_CAP_12P5 = 2'h2
  } osbsc_cap_t;

  typedef enum logic {
    OSBSC_SUP_MAIN = 1'b0,
    OSBSC_SUP_BAT  = 1'b1
  } osbsc_supply_t;

endpackage

// ### osbsc_sup_if.sv
`timescale 1ns/1ps
`default_nettype none

interface osbsc_sup_if;
  logic on_battery;
  logic to_bat_evt;
  logic to_main_evt;

  modport mon  (output on_battery, output to_bat_evt, output to_main_evt);
  modport core (input on_battery, input to_bat_evt, input to_main_evt);
endinterface : osbsc_sup_if

`default_nettype wire

// ### osbsc_supply_mon.sv
`timescale 1ns/1ps
`default_nettype none

module osbsc_supply_mon
  import osbsc_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  battery_level_i,
  input  wire logic  switch_disable_i,
  osbsc_sup_if.mon   sup
);

  logic          sync_a;
  logic          sync_b;
  osbsc_supply_t state;
  osbsc_supply_t next_state;

  // A disabled changeover circuit never reports battery operation.
  wire logic want_bat = sync_b & ~switch_disable_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= battery_level_i; // [R18]
      sync_b <= sync_a;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      OSBSC_SUP_MAIN: if (want_bat) next_state = OSBSC_SUP_BAT;
      OSBSC_SUP_BAT:  if (!want_bat) next_state = OSBSC_SUP_MAIN;
      default:        next_state = OSBSC_SUP_MAIN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= OSBSC_SUP_MAIN;
      sup.to_bat_evt  <= 1'b0;
      sup.to_main_evt <= 1'b0;
    end else begin
      state           <= next_state;
      sup.to_bat_evt  <= (state == OSBSC_SUP_MAIN) && (next_state == OSBSC_SUP_BAT);  // [R15]
      sup.to_main_evt <= (state == OSBSC_SUP_BAT) && (next_state == OSBSC_SUP_MAIN);
    end
  end

  assign sup.on_battery = (state == OSBSC_SUP_BAT);

endmodule : osbsc_supply_mon

`default_nettype wire

// ### osbsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "osbsc_defs.svh"

// Notes on behaviour
// [R01] Oscillator control register at index 25h.
// [R02] Invert bit flips clock, moves low-jitter edge.
// [R03] Hour format bit selects 24 or 12-hour.
// [R04] Stop-watch mode ignores the hour format bit.
// [R05] Low jitter bit enables reduced-jitter clock output.
// [R06] Drive field: normal, low, high, high.
// [R07] Load cap field: 7.0, 6.0, 12.5, 12.5 pF.
// [R08] Software uses 7.0 pF for 9.0 pF crystals.
// [R09] Flag set on battery; readable only on main.
// [R10] Battery changeover gives pulse or static low.
// [R11] Battery: bus ignored, clock and stamp Hi-Z.
// [R12] Mechanical switch detector works on any supply.
// [R13] Interrupt pin stays active, clock function disabled.
// [R14] Supply switch control register at index 26h.
// [R15] Disable bit shuts the whole changeover circuit.
// [R16] Flag stays set until software clears it.
// [R17] Every changeover pulses, even with flag set.
// [R18] Supply state synchronised before use.
// [R19] Registers reset to zero, unused bits zero.
module osbsc_top
  import osbsc_pkg::*;
#(
  parameter int PULSE_CYCLES = `OSBSC_INT_PULSE_NS / `OSBSC_CLK_PERIOD_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        battery_level_i,
  input  wire logic        stopwatch_mode_i,
  input  wire logic        clk_sel_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        ts_out_i,
  input  wire logic        ts_out_en_i,
  input  wire logic        ts_digital_i,
  input  wire logic        ts_switch_i,
  output logic             clk_out_o,
  output logic             clk_out_oe_o,
  output logic             scl_gated_o,
  output logic             sda_gated_o,
  output logic             ts_out_o,
  output logic             ts_out_oe_o,
  output logic             ts_digital_o,
  output logic             ts_switch_o,
  output logic             int_a_o,
  output logic             int_a_oe_o,
  output logic             irq_o,
  output logic             on_battery_o,
  output logic             hour_12h_o,
  output logic             offset_cal_mode_o,
  output logic             low_jitter_o,
  output logic             low_jitter_falling_o,
  output osbsc_drive_t     drive_level_o,
  output osbsc_cap_t       load_cap_o,
  output logic             switch_disable_o,
  output logic             switch_refresh_o,
  output logic [1:0]       switch_mode_o,
  output logic             switch_threshold_o
);

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  generate
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("PULSE_CYCLES must be at least one");
    end
  endgenerate

  // ****************************************************************
  // Decode helpers.
  // ****************************************************************
  function automatic osbsc_drive_t decode_drive(input logic [1:0] code);
    osbsc_drive_t d;
    case (code)
      2'h0:    d = OSBSC_DRIVE_NORMAL;
      2'h1:    d = OSBSC_DRIVE_LOW;
      default: d = OSBSC_DRIVE_HIGH; // [R06]
    endcase
    return d;
  endfunction

  function automatic osbsc_cap_t decode_cap(input logic [1:0] code);
    osbsc_cap_t c;
    case (code)
      2'h0:    c = OSBSC_CAP_7P0;
      2'h1:    c = OSBSC_CAP_6P0;
      default: c = OSBSC_CAP_12P5; // [R07]
    endcase
    return c;
  endfunction

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [7:0]    osc_ctrl;
  logic [7:0]    sup_ctrl;
  logic          backup_switch_flag;
  logic [1:0]    int_status;
  logic [1:0]    int_enable;
  logic [3:0]    interrupt_out_a_ctrl;
  logic [CW-1:0] pulse_cnt;

  osbsc_sup_if sup ();

  osbsc_supply_mon u_mon (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .battery_level_i  (battery_level_i),
    .switch_disable_i (sup_ctrl[`OSBSC_SUP_DISABLE]),
    .sup              (sup.mon)
  );

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  // On battery the host side is dead, so accesses are still answered to
  // avoid a hung master, but writes are dropped and reads return zero.
  wire logic       on_bat   = sup.on_battery;
  wire logic [5:0] idx      = wb_adr_i[7:2];
  wire logic       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic       wr_ok    = req & wb_we_i & wb_sel_i[0] & ~on_bat; // [R11]
  wire logic [7:0] wbyte    = wb_dat_i[7:0];
  wire logic       wr_osc   = wr_ok & (idx == `OSBSC_IDX_OSC_CTRL);
  wire logic       wr_sup   = wr_ok & (idx == `OSBSC_IDX_SUP_CTRL);
  wire logic       wr_flags = wr_ok & (idx == `OSBSC_IDX_FLAGS);
  wire logic       wr_clr   = wr_ok & (idx == `OSBSC_IDX_INT_CLEAR);
  wire logic       wr_ien   = wr_ok & (idx == `OSBSC_IDX_INT_ENABLE);
  wire logic       wr_interrupt_out_a  = wr_ok & (idx == `OSBSC_IDX_INTERRUPT_OUT_A_CTRL);
  wire logic [1:0] events   = {sup.to_main_evt, sup.to_bat_evt};

  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `OSBSC_IDX_OSC_CTRL:   rd_byte = osc_ctrl; // [R01]
      `OSBSC_IDX_SUP_CTRL:   rd_byte = sup_ctrl & `OSBSC_SUP_MASK; // [R14] [R19]
      `OSBSC_IDX_FLAGS:      rd_byte = {7'h00, backup_switch_flag}; // [R09]
      `OSBSC_IDX_INT_STATUS: rd_byte = {6'h00, int_status};
      `OSBSC_IDX_INT_ENABLE: rd_byte = {6'h00, int_enable};
      `OSBSC_IDX_INTERRUPT_OUT_A_CTRL:  rd_byte = {4'h0, interrupt_out_a_ctrl};
      default:               rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !on_bat) ? {24'h00_0000, rd_byte} : 32'h0000_0000; // [R09]
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_ctrl  <= `OSBSC_RST_OSC_CTRL; // [R19]
      sup_ctrl  <= `OSBSC_RST_SUP_CTRL;
      int_enable <= 2'h0;
      interrupt_out_a_ctrl <= 4'h0;
    end else begin
      if (wr_osc) osc_ctrl <= wbyte; // [R01]
      if (wr_sup) sup_ctrl <= wbyte & `OSBSC_SUP_MASK; // [R14] [R19]
      if (wr_ien) int_enable <= wbyte[1:0];
      if (wr_interrupt_out_a) interrupt_out_a_ctrl <= wbyte[3:0];
    end
  end

  // ****************************************************************
  // Flag and sticky status.
  // ****************************************************************
  // A changeover in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backup_switch_flag <= 1'b0;
      int_status         <= 2'h0;
    end else begin
      if (sup.to_bat_evt) begin
        backup_switch_flag <= 1'b1; // [R09] [R16]
      end else if (wr_flags && !wbyte[`OSBSC_FLAG_BACKUP]) begin
        backup_switch_flag <= 1'b0; // [R16]
      end
      int_status <= events | (int_status & ~(wr_clr ? wbyte[1:0] : 2'h0));
    end
  end

  // ****************************************************************
  // Interrupt pin.
  // ****************************************************************
  // The pulse length stands in for one to two slow-clock periods; it is
  // restarted by each changeover, so back-to-back switches still pulse.
  wire logic chg_int   = interrupt_out_a_ctrl[`OSBSC_INTERRUPT_OUT_A_EN];
  wire logic pulse_go  = chg_int & (sup.to_bat_evt | sup.to_main_evt); // [R17]
  wire logic pulse_on  = (pulse_cnt != '0);
  wire logic level_on  = chg_int & backup_switch_flag;
  wire logic assert_lo = interrupt_out_a_ctrl[`OSBSC_INTERRUPT_OUT_A_BATIND] ? on_bat :
                         interrupt_out_a_ctrl[`OSBSC_INTERRUPT_OUT_A_LEVEL]  ? level_on : pulse_on; // [R10]
  wire logic clk_mode  = interrupt_out_a_ctrl[`OSBSC_INTERRUPT_OUT_A_CLK] & ~interrupt_out_a_ctrl[`OSBSC_INTERRUPT_OUT_A_BATIND];
  wire logic clk_src   = clk_sel_i ^ osc_ctrl[`OSBSC_OSC_INVERT]; // [R02]
  wire logic interrupt_out_a_low  = (clk_mode && !on_bat) ? ~clk_src : assert_lo; // [R13]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt <= '0;
    end else if (pulse_go) begin
      pulse_cnt <= CW'(PULSE_CYCLES); // [R17]
    end else if (pulse_on) begin
      pulse_cnt <= pulse_cnt - CW'(1);
    end
  end

  // ****************************************************************
  // Pin and configuration outputs.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_o            <= 1'b0;
      clk_out_oe_o         <= 1'b0;
      scl_gated_o          <= 1'b1;
      sda_gated_o          <= 1'b1;
      ts_out_o             <= 1'b0;
      ts_out_oe_o          <= 1'b0;
      ts_digital_o         <= 1'b0;
      ts_switch_o          <= 1'b1;
      int_a_o              <= 1'b0;
      int_a_oe_o           <= 1'b0;
      irq_o                <= 1'b0;
      on_battery_o         <= 1'b0;
    end else begin
      clk_out_o            <= on_bat ? 1'b0 : clk_src; // [R02] [R11]
      clk_out_oe_o         <= ~on_bat; // [R11]
      scl_gated_o          <= on_bat ? 1'b1 : scl_i; // [R11]
      sda_gated_o          <= on_bat ? 1'b1 : sda_i;
      ts_out_o             <= on_bat ? 1'b0 : ts_out_i;
      ts_out_oe_o          <= ts_out_en_i & ~on_bat; // [R11]
      ts_digital_o         <= on_bat ? 1'b0 : ts_digital_i;
      ts_switch_o          <= ts_switch_i; // [R12]
      int_a_o              <= 1'b0;
      int_a_oe_o           <= interrupt_out_a_low; // [R10] [R13]
      irq_o                <= |(int_status & int_enable);
      on_battery_o         <= on_bat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hour_12h_o           <= 1'b0;
      offset_cal_mode_o    <= 1'b0;
      low_jitter_o         <= 1'b0;
      low_jitter_falling_o <= 1'b0;
      drive_level_o        <= OSBSC_DRIVE_NORMAL;
      load_cap_o           <= OSBSC_CAP_7P0;
      switch_disable_o     <= 1'b0;
      switch_refresh_o     <= 1'b0;
      switch_mode_o        <= 2'h0;
      switch_threshold_o   <= 1'b0;
    end else begin
      hour_12h_o           <= osc_ctrl[`OSBSC_OSC_HOUR12] & ~stopwatch_mode_i; // [R03] [R04]
      offset_cal_mode_o    <= osc_ctrl[`OSBSC_OSC_OFFSET_CAL_MODE];
      low_jitter_o         <= osc_ctrl[`OSBSC_OSC_LOW_JITTER_SELECT]; // [R05]
      low_jitter_falling_o <= osc_ctrl[`OSBSC_OSC_INVERT]; // [R02]
      drive_level_o        <= decode_drive(osc_ctrl[`OSBSC_OSC_DRIVE_HI:`OSBSC_OSC_DRIVE_LO]);
      load_cap_o           <= decode_cap(osc_ctrl[`OSBSC_OSC_CAP_HI:`OSBSC_OSC_CAP_LO]);
      switch_disable_o     <= sup_ctrl[`OSBSC_SUP_DISABLE]; // [R15]
      switch_refresh_o     <= sup_ctrl[`OSBSC_SUP_REFRESH];
      switch_mode_o        <= sup_ctrl[`OSBSC_SUP_MODE_HI:`OSBSC_SUP_MODE_LO];
      switch_threshold_o   <= sup_ctrl[`OSBSC_SUP_THRESH];
    end
  end

endmodule : osbsc_top

`default_nettype wire

// ### osbsc_top_unused_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### osbsc_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Analog supply switch seen as a filtered comparator level.
// ****************************************************************
module osbsc_switch_model #(
  parameter int LAG = 1
) (
  input  wire logic clk_i,
  input  wire logic bat_req_i,
  output logic      level_o
);
  logic [7:0] pipe = 8'h00;

  // A larger lag stands for a slow comparator; the level only moves after an edge.
  always_ff @(posedge clk_i) begin
    pipe    <= {pipe[6:0], bat_req_i};
    level_o <= pipe[LAG-1];
  end
endmodule // osbsc_switch_model

`default_nettype wire

// ### osbsc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module osbsc_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        battery_level_i,
  input  wire logic        switch_disable_o,
  input  wire logic        on_battery_o,
  input  wire logic        clk_out_oe_o,
  input  wire logic        ts_out_oe_o,
  input  wire logic        scl_i,
  input  wire logic        scl_gated_o,
  input  wire logic        stopwatch_mode_i,
  input  wire logic        hour_12h_o,
  input  wire logic        ts_switch_i,
  input  wire logic        ts_switch_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Two sync flops, a state flop and one output flop need five samples; six leave one spare.
  sequence seq_bat_held;
    (battery_level_i && !switch_disable_o) [*6];
  endsequence

  chk_ack_after_take: assert property (seq_take |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_bat_latency: assert property (seq_bat_held |-> on_battery_o)
    else $error("battery state late");
  chk_bat_pins_off: assert property (on_battery_o |-> !clk_out_oe_o && !ts_out_oe_o && scl_gated_o)
    else $error("pins active on battery");
  chk_main_clk_on: assert property ($fell(on_battery_o) |-> clk_out_oe_o)
    else $error("clock output off on main");
  chk_main_scl_pass: assert property (!on_battery_o [*2] |-> scl_gated_o == $past(scl_i))
    else $error("bus clock not passed on main");
  chk_stopwatch_24h: assert property (stopwatch_mode_i |=> !hour_12h_o)
    else $error("hour format used in stop-watch");
  chk_switch_live: assert property ($changed(ts_switch_i) |=> ts_switch_o == $past(ts_switch_i))
    else $error("switch detector not following");
  chk_bat_read_zero: assert property ($past(on_battery_o) && $past(wb_ack_o) && !$past(wb_we_i, 2)
    |-> $past(wb_dat_o) == 32'h0)
    else $error("read data on battery");
endmodule // osbsc_chk

bind osbsc_top osbsc_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_dat_o, .battery_level_i, .switch_disable_o, .on_battery_o, .clk_out_oe_o, .ts_out_oe_o,
  .scl_i, .scl_gated_o, .stopwatch_mode_i, .hour_12h_o, .ts_switch_i, .ts_switch_o);

`default_nettype wire

// ### test_osbsc_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module test_osbsc_top;
  import osbsc_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, battery_level_i, stopwatch_mode_i, clk_sel_i;
  logic scl_i, sda_i, ts_out_i, ts_out_en_i, ts_digital_i, ts_switch_i, bat_req, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic clk_out_o, clk_out_oe_o, scl_gated_o, sda_gated_o, ts_out_o, ts_out_oe_o, ts_digital_o;
  logic ts_switch_o, int_a_o, int_a_oe_o, irq_o, on_battery_o, hour_12h_o, offset_cal_mode_o;
  logic low_jitter_o, low_jitter_falling_o, switch_disable_o, switch_refresh_o, switch_threshold_o;
  logic [1:0]   switch_mode_o;
  osbsc_drive_t drive_level_o;
  osbsc_cap_t   load_cap_o;
  int           err_total, n_tests;

  osbsc_top #(.PULSE_CYCLES(8)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .battery_level_i, .stopwatch_mode_i, .clk_sel_i,
    .scl_i, .sda_i, .ts_out_i, .ts_out_en_i, .ts_digital_i, .ts_switch_i, .clk_out_o,
    .clk_out_oe_o, .scl_gated_o, .sda_gated_o, .ts_out_o, .ts_out_oe_o, .ts_digital_o,
    .ts_switch_o, .int_a_o, .int_a_oe_o, .irq_o, .on_battery_o, .hour_12h_o, .offset_cal_mode_o,
    .low_jitter_o, .low_jitter_falling_o, .drive_level_o, .load_cap_o, .switch_disable_o,
    .switch_refresh_o, .switch_mode_o, .switch_threshold_o);
  osbsc_switch_model #(.LAG(1)) u_sw (.clk_i, .bat_req_i(bat_req), .level_o(battery_level_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Bus and waiting helpers.
  // ****************************************************************
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    `CHK("ack", 1'b1, wb_ack_o)
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
    xfer(1'b0, adr, 8'h00);
    `CHK("read data", e, rd)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_bat(input logic v);
    int n;
    n = 0;
    while (on_battery_o !== v && n < 30) begin @(posedge clk_i); n++; end
    `CHK("on_battery_o", v, on_battery_o)
  endtask

  task automatic t_defaults;
    rd_chk(8'h94, 32'h0);
    rd_chk(8'h98, 32'h0);
    `CHK("drive", OSBSC_DRIVE_NORMAL, drive_level_o)
    `CHK("cap", OSBSC_CAP_7P0, load_cap_o)
    `CHK("clk out", clk_sel_i, clk_out_o)
    `CHK("main pins", 6'h3E, {clk_out_oe_o, ts_out_oe_o, sda_gated_o, ts_out_o, ts_digital_o, int_a_o})
  endtask

  task automatic t_osc;
    logic [3:0] k;
    osbsc_drive_t ed;
    osbsc_cap_t ec;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      ed = osbsc_drive_t'(k[3] ? 2'h2 : {1'b0, k[2]});
      ec = osbsc_cap_t'(k[1] ? 2'h2 : {1'b0, k[0]});
      xfer(1'b1, 8'h94, {k, k});
      cyc(2);
      `CHK("drive", ed, drive_level_o)
      `CHK("cap", ec, load_cap_o)
      `CHK("clk out", clk_sel_i ^ k[3], clk_out_o)
      `CHK("jitter edge", k[3], low_jitter_falling_o)
      `CHK("offset mode", k[2], offset_cal_mode_o)
      `CHK("hour 12", k[1], hour_12h_o)
      `CHK("low jitter", k[0], low_jitter_o)
      rd_chk(8'h94, {24'h0, k, k});
    end
    stopwatch_mode_i <= 1'b1;
    cyc(2);
    `CHK("hour 12", 1'b0, hour_12h_o)
    stopwatch_mode_i <= 1'b0;
    xfer(1'b1, 8'h94, 8'h00);
    cyc(2);
    `CHK("cap", OSBSC_CAP_7P0, load_cap_o)
  endtask

  task automatic t_sup;
    xfer(1'b1, 8'h98, 8'hFF);
    rd_chk(8'h98, 32'h1F);
    `CHK("switch mode", 2'h3, switch_mode_o)
    `CHK("sw flags", 3'h7, {switch_disable_o, switch_refresh_o, switch_threshold_o})
    bat_req <= 1'b1;
    cyc(12);
    `CHK("on_battery_o", 1'b0, on_battery_o)
    bat_req <= 1'b0;
    xfer(1'b1, 8'h00, 8'h55);
    rd_chk(8'h00, 32'h0);
    xfer(1'b1, 8'h98, 8'h00);
    cyc(6);
  endtask

  task automatic t_battery;
    xfer(1'b1, 8'hC8, 8'h03);
    xfer(1'b1, 8'hCC, 8'h01);
    scl_i <= 1'b0;
    bat_req <= 1'b1;
    wait_bat(1'b1);
    `CHK("pins", 6'h0C, {clk_out_oe_o, ts_out_oe_o, scl_gated_o, sda_gated_o, ts_digital_o, ts_out_o})
    cyc(1);
    `CHK("int pin", 2'h3, {irq_o, int_a_oe_o})
    ts_switch_i <= 1'b0;
    cyc(2);
    `CHK("switch", 1'b0, ts_switch_o)
    ts_switch_i <= 1'b1;
    rd_chk(8'hAC, 32'h0);
    xfer(1'b1, 8'h94, 8'hFF);
    bat_req <= 1'b0;
    wait_bat(1'b0);
    rd_chk(8'h94, 32'h0);
    rd_chk(8'hAC, 32'h1);
    rd_chk(8'hC0, 32'h3);
    cyc(12);
    `CHK("int pin", 1'b0, int_a_oe_o)
    bat_req <= 1'b1;
    wait_bat(1'b1);
    cyc(1);
    `CHK("int pin", 1'b1, int_a_oe_o)
    bat_req <= 1'b0;
    wait_bat(1'b0);
    cyc(1);
    `CHK("int pin", 1'b1, int_a_oe_o)
    rd_chk(8'hAC, 32'h1);
    xfer(1'b1, 8'hC4, 8'h03);
    cyc(3);
    `CHK("irq", 1'b0, irq_o)
    xfer(1'b1, 8'hAC, 8'h00);
    rd_chk(8'hAC, 32'h0);
  endtask

  task automatic t_interrupt_out_a;
    xfer(1'b1, 8'hCC, 8'h04);
    bat_req <= 1'b1;
    wait_bat(1'b1);
    cyc(1);
    `CHK("indicator", 1'b1, int_a_oe_o)
    bat_req <= 1'b0;
    wait_bat(1'b0);
    cyc(1);
    `CHK("indicator", 1'b0, int_a_oe_o)
    xfer(1'b1, 8'hCC, 8'h03);
    cyc(2);
    `CHK("level int", 1'b1, int_a_oe_o)
    xfer(1'b1, 8'hAC, 8'h00);
    cyc(2);
    `CHK("level int", 1'b0, int_a_oe_o)
    xfer(1'b1, 8'hCC, 8'h08);
    clk_sel_i <= 1'b0;
    cyc(2);
    `CHK("clock pin", 1'b1, int_a_oe_o)
    clk_sel_i <= 1'b1;
    cyc(2);
    `CHK("clock pin", 1'b0, int_a_oe_o)
    xfer(1'b1, 8'hCC, 8'h00);
  endtask

  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    {rst_i, wb_sel_i, clk_sel_i, scl_i, sda_i, ts_out_i, ts_out_en_i} = 10'h3FF;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h0;
    {ts_digital_i, ts_switch_i, bat_req, stopwatch_mode_i} = 4'hC;
    wb_sel_i = 4'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults;
    t_osc;
    t_sup;
    t_battery;
    t_interrupt_out_a;
    end_of_test;
  end

  // The run needs well under a thousand cycles; a hang stops after four thousand.
  initial begin
    #(25 * 4000);
    err_total++;
    end_of_test;
  end
endmodule // test_osbsc_top

`default_nettype wire
